// file: design/arc_pkg.sv
// Purpose: constants for the auto-reload timer with capture
// Assumes: byte-wide special-function register port, bit-addressable control
// Notes:   count and reload offsets sit beside the control register
package arc_pkg;

    // register offsets
    localparam logic [7:0] ADDR_CONTROL     = 8'hC8;
    localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LOW   = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hCD;

    // control field positions
    localparam int CTL_HIGH_FLAG = 7;
    localparam int CTL_LOW_FLAG  = 6;
    localparam int CTL_LOW_IRQEN = 5;
    localparam int CTL_CAPTURE   = 4;
    localparam int CTL_SPLIT     = 3;
    localparam int CTL_RUN       = 2;
    localparam int CTL_XCLK_LSB  = 0;

    // reset values and half-count maximum
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET   = 8'h00;
    localparam logic [7:0] RELOAD_RESET  = 8'h00;
    localparam logic [7:0] HALF_MAX      = 8'hFF;

    // external clock select codes
    localparam logic [1:0] XCLK_SYS_DIV12 = 2'h0;
    localparam logic [1:0] XCLK_RTC_DIV8  = 2'h1;
    localparam logic [1:0] XCLK_RESERVED  = 2'h2;
    localparam logic [1:0] XCLK_CMP0      = 2'h3;

    // timing counts
    localparam int         SYS_DIVIDE    = 12;
    localparam logic [3:0] SYS_DIV_LAST  = 4'(SYS_DIVIDE - 1);
    localparam int         RTC_DIVIDE    = 8;
    localparam logic [2:0] RTC_DIV_LAST  = 3'(RTC_DIVIDE - 1);

endpackage

// file: design/arc_timer.sv
// Purpose: 16-bit / dual 8-bit auto-reload timer with capture mode
// Assumes: single core clock, synchronous active-low reset, SFR byte port
// Notes:   read data appears one cycle after the read strobe
//
// Contract
// RQ1 - count is two separately accessible 8-bit halves
// RQ2 - split bit clear: one 16-bit auto-reload counter
// RQ3 - 16-bit wrap reloads pair, sets high flag
// RQ4 - 16-bit overflow interrupts when core enable set
// RQ5 - low-half wrap interrupts when low enable set
// RQ6 - split: halves reload from own reload registers
// RQ7 - split: run gates high half only
// RQ8 - per-half clock select; external select field
// RQ9 - rtc and comparator synchronised before use
// RQ10 - split: each half wrap sets its flag
// RQ11 - split: interrupt on high, either if enabled
// RQ12 - flags never cleared by hardware
// RQ13 - capture mode follows capture enable bit
// RQ14 - software picks 16-bit mode before capture
// RQ15 - capture source: comparator edge or rtc/8
// RQ16 - capture copies count to reload, sets flag
// RQ17 - software uses fast clock, subtracts captures
// RQ18 - control register layout, bit-addressable, reset zero
// RQ19 - 16-bit and capture count only while running
`timescale 1ns/1ns
module arc_timer (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // special-function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // bit-addressed write port
    input  wire logic [7:0] bit_addr,
    input  wire logic       bit_wr,
    input  wire logic       bit_wdata,
    // clock selects and core enable
    input  wire logic       high_half_clock_select,
    input  wire logic       low_half_clock_select,
    input  wire logic       core_timer_irq_enable,
    // asynchronous sources
    input  wire logic       rtc_clk_in,
    input  wire logic       cmp0_out,
    // interrupt request
    output logic            timer_irq
);

    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] cnt_low_q;
    logic [7:0] cnt_high_q;
    logic [7:0] rel_low_q;
    logic [7:0] rel_high_q;
    logic [7:0] rdata_q;
    logic       irq_q;
    logic [3:0] div12_q;
    logic [2:0] rtc_div_q;
    logic       rtc_meta_q;
    logic       rtc_sync_q;
    logic       rtc_prev_q;
    logic       cmp_meta_q;
    logic       cmp_sync_q;
    logic       cmp_prev_q;

    logic       div12_tick;
    logic       rtc8_tick;
    logic       cmp_tick;
    logic       low_tick;
    logic       high_tick;
    logic [1:0] xclk;
    logic       split;
    logic       run;
    logic       capen;
    logic       low_inc;
    logic       low_wrap;
    logic       low_reload;
    logic       high_inc;
    logic       high_wrap;
    logic       high_reload;
    logic       cap_event;
    logic       high_set;
    logic       low_set;
    logic       wr_cnt_low;
    logic       wr_cnt_high;
    logic       wr_rel_low;
    logic       wr_rel_high;
    logic       wr_ctl;
    logic       bit_hit;

    assign xclk  = ctl_q[arc_pkg::CTL_XCLK_LSB +: 2];
    assign split = ctl_q[arc_pkg::CTL_SPLIT];
    assign run   = ctl_q[arc_pkg::CTL_RUN];
    assign capen = ctl_q[arc_pkg::CTL_CAPTURE];

    assign wr_ctl      = sfr_wr && (sfr_addr == arc_pkg::ADDR_CONTROL);
    assign wr_cnt_low  = sfr_wr && (sfr_addr == arc_pkg::ADDR_COUNT_LOW);
    assign wr_cnt_high = sfr_wr && (sfr_addr == arc_pkg::ADDR_COUNT_HIGH);
    assign wr_rel_low  = sfr_wr && (sfr_addr == arc_pkg::ADDR_RELOAD_LOW);
    assign wr_rel_high = sfr_wr && (sfr_addr == arc_pkg::ADDR_RELOAD_HIGH);
    // bit addresses of the control register are its byte address plus bit index
    assign bit_hit     = bit_wr && (bit_addr[7:3] == arc_pkg::ADDR_CONTROL[7:3]);

    // two-stage synchronisers; only the second stage feeds edge logic
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rtc_meta_q <= 1'b0;
            rtc_sync_q <= 1'b0;
            rtc_prev_q <= 1'b0;
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
            cmp_prev_q <= 1'b0;
        end else begin
            rtc_meta_q <= rtc_clk_in;               // [RQ9]
            rtc_sync_q <= rtc_meta_q;
            rtc_prev_q <= rtc_sync_q;
            cmp_meta_q <= cmp0_out;                 // [RQ9]
            cmp_sync_q <= cmp_meta_q;
            cmp_prev_q <= cmp_sync_q;
        end
    end

    assign cmp_tick  = cmp_sync_q && !cmp_prev_q;
    assign rtc8_tick = rtc_sync_q && !rtc_prev_q && (rtc_div_q == arc_pkg::RTC_DIV_LAST);
    assign div12_tick = (div12_q == arc_pkg::SYS_DIV_LAST);

    // prescalers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            div12_q <= 4'h0;
        end else if (div12_tick) begin
            div12_q <= 4'h0;
        end else begin
            div12_q <= div12_q + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rtc_div_q <= 3'h0;
        end else if (rtc_sync_q && !rtc_prev_q) begin
            rtc_div_q <= rtc_div_q + 3'h1;
        end
    end

    // reserved code gives no ticks unless the half's clock select picks the core clock
    function automatic logic pick_tick(input logic       sys_sel,
                                       input logic [1:0] sel,
                                       input logic       t12,
                                       input logic       t8,
                                       input logic       tc);
        logic t;
        t = 1'b0;
        if (sys_sel) begin
            t = 1'b1;
        end else begin
            unique case (sel)
                arc_pkg::XCLK_SYS_DIV12: t = t12;
                arc_pkg::XCLK_RTC_DIV8:  t = t8;
                arc_pkg::XCLK_RESERVED:  t = 1'b0;
                arc_pkg::XCLK_CMP0:      t = tc;
            endcase
        end
        return t;
    endfunction

    assign low_tick  = pick_tick(low_half_clock_select, xclk, div12_tick, rtc8_tick,
                                 cmp_tick);                                       // [RQ8]
    assign high_tick = pick_tick(high_half_clock_select, xclk, div12_tick, rtc8_tick,
                                 cmp_tick);                                       // [RQ8]

    // count enables and wraps
    assign low_inc  = split ? low_tick : (run && low_tick);            // [RQ7] [RQ19]
    assign low_wrap = low_inc && (cnt_low_q == arc_pkg::HALF_MAX);
    assign high_inc = split ? (run && high_tick) : low_wrap;           // [RQ2] [RQ7]
    assign high_wrap = high_inc && (cnt_high_q == arc_pkg::HALF_MAX);
    // capture mode lets the count run free so differences stay valid
    assign high_reload = high_wrap && (split || !capen);               // [RQ3] [RQ6]
    assign low_reload  = split ? low_wrap : (high_wrap && !capen);     // [RQ3] [RQ6]
    assign cap_event   = capen && (xclk[1] ? cmp_tick : rtc8_tick);    // [RQ13] [RQ15]

    assign high_set = high_wrap || cap_event;                          // [RQ10] [RQ16]
    assign low_set  = low_wrap;                                        // [RQ10]

    // control register: byte write, then bit write, then hardware sets win
    always_comb begin
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d = sfr_wdata;
        end
        if (bit_hit) begin
            ctl_d[bit_addr[2:0]] = bit_wdata;                          // [RQ18]
        end
        ctl_d[arc_pkg::CTL_HIGH_FLAG] = ctl_d[arc_pkg::CTL_HIGH_FLAG] || high_set;
        ctl_d[arc_pkg::CTL_LOW_FLAG]  = ctl_d[arc_pkg::CTL_LOW_FLAG] || low_set;
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctl_q <= arc_pkg::CONTROL_RESET;                           // [RQ18]
        end else begin
            ctl_q <= ctl_d;                                            // [RQ12]
        end
    end

    // count halves; a software write beats a tick in the same cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cnt_low_q <= arc_pkg::COUNT_RESET;
        end else if (wr_cnt_low) begin
            cnt_low_q <= sfr_wdata;                                    // [RQ1]
        end else if (low_reload) begin
            cnt_low_q <= rel_low_q;                                    // [RQ3] [RQ6]
        end else if (low_inc) begin
            cnt_low_q <= cnt_low_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cnt_high_q <= arc_pkg::COUNT_RESET;
        end else if (wr_cnt_high) begin
            cnt_high_q <= sfr_wdata;                                   // [RQ1]
        end else if (high_reload) begin
            cnt_high_q <= rel_high_q;                                  // [RQ3] [RQ6]
        end else if (high_inc) begin
            cnt_high_q <= cnt_high_q + 8'h01;
        end
    end

    // reload pair; a capture beats a software write
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rel_low_q  <= arc_pkg::RELOAD_RESET;
            rel_high_q <= arc_pkg::RELOAD_RESET;
        end else if (cap_event) begin
            rel_low_q  <= cnt_low_q;                                   // [RQ16]
            rel_high_q <= cnt_high_q;
        end else begin
            if (wr_rel_low) begin
                rel_low_q <= sfr_wdata;
            end
            if (wr_rel_high) begin
                rel_high_q <= sfr_wdata;
            end
        end
    end

    // registered read data; unmapped offsets read zero
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                arc_pkg::ADDR_CONTROL:     rdata_q <= ctl_q;
                arc_pkg::ADDR_COUNT_LOW:   rdata_q <= cnt_low_q;
                arc_pkg::ADDR_COUNT_HIGH:  rdata_q <= cnt_high_q;
                arc_pkg::ADDR_RELOAD_LOW:  rdata_q <= rel_low_q;
                arc_pkg::ADDR_RELOAD_HIGH: rdata_q <= rel_high_q;
                default:                   rdata_q <= 8'h00;
            endcase
        end
    end

    // with core enable set, level request while the high flag or an enabled low flag stands; software clears the flag to drop it
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= core_timer_irq_enable &&
                     (ctl_q[arc_pkg::CTL_HIGH_FLAG] ||
                      (ctl_q[arc_pkg::CTL_LOW_IRQEN] &&
                       ctl_q[arc_pkg::CTL_LOW_FLAG]));                 // [RQ4] [RQ5] [RQ11]
        end
    end

    assign sfr_rdata = rdata_q;
    assign timer_irq = irq_q;

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence quiet_div12;
        !div12_tick [*8] ##1 !div12_tick [*3];
    endsequence

    sequence no_count_write;
        !wr_cnt_low && !wr_cnt_high;
    endsequence

    a_div12_spacing: assert property (div12_tick |=> quiet_div12 ##1 div12_tick) // [RQ8]
        else $error("divide-by-12 tick spacing wrong");

    a_full_reload: assert property (                                   // [RQ3]
        (!split && !capen && high_wrap) ##0 no_count_write
        |=> {cnt_high_q, cnt_low_q} == {$past(rel_high_q), $past(rel_low_q)}
            && ctl_q[arc_pkg::CTL_HIGH_FLAG])
        else $error("16-bit wrap did not reload and flag");

    a_split_low_free: assert property (                                // [RQ7]
        (split && low_tick && !low_wrap && !wr_cnt_low)
        |=> cnt_low_q == $past(cnt_low_q) + 8'h01)
        else $error("split low half failed to count");

    a_split_high_gated: assert property (                              // [RQ7]
        (split && !run && !wr_cnt_high) |=> $stable(cnt_high_q))
        else $error("split high half counted while stopped");

    a_stopped_hold: assert property (                                  // [RQ19]
        (!split && !run) ##0 no_count_write
        |=> $stable(cnt_low_q) && $stable(cnt_high_q))
        else $error("16-bit counter moved while stopped");

    a_low_flag_set: assert property (low_wrap |=> ctl_q[arc_pkg::CTL_LOW_FLAG]) // [RQ10]
        else $error("low flag not set on wrap");

    a_flag_sticky: assert property (                                   // [RQ12]
        (ctl_q[arc_pkg::CTL_HIGH_FLAG] && !wr_ctl && !bit_hit)
        |=> ctl_q[arc_pkg::CTL_HIGH_FLAG])
        else $error("high flag cleared by hardware");

    a_capture_copy: assert property (                                  // [RQ16]
        cap_event |=> {rel_high_q, rel_low_q} == {$past(cnt_high_q), $past(cnt_low_q)}
                      && ctl_q[arc_pkg::CTL_HIGH_FLAG])
        else $error("capture did not copy count");

    a_irq_follow: assert property (                                    // [RQ4] [RQ11]
        (core_timer_irq_enable && high_set && !wr_ctl && !bit_hit)
        ##1 core_timer_irq_enable |=> timer_irq)
        else $error("overflow did not raise interrupt");

    // low wrap interrupts only while its own enable still stands
    a_low_irq: assert property (                                       // [RQ5] [RQ11]
        (core_timer_irq_enable && ctl_q[arc_pkg::CTL_LOW_IRQEN] && low_wrap
         && !wr_ctl && !bit_hit)
        ##1 (core_timer_irq_enable && ctl_q[arc_pkg::CTL_LOW_IRQEN])
        |=> timer_irq)
        else $error("low wrap did not raise interrupt");

    a_irq_quiet: assert property (!core_timer_irq_enable |=> !timer_irq) // [RQ4]
        else $error("interrupt raised while disabled");

endmodule

// file: tb/arc_timer_test.sv
// Purpose: self-checking bench for the auto-reload timer with capture
// Assumes: sources toggle on core clock edges, slow against the core clock
// Notes:   counts are read while stopped, except the split low half, read running and masked to its upper nibble
`timescale 1ns/1ns
module arc_timer_test;
    localparam logic [7:0] CT = arc_pkg::ADDR_CONTROL;
    localparam logic [7:0] RL = arc_pkg::ADDR_RELOAD_LOW;
    localparam logic [7:0] RH = arc_pkg::ADDR_RELOAD_HIGH;
    localparam logic [7:0] CL = arc_pkg::ADDR_COUNT_LOW;
    localparam logic [7:0] CH = arc_pkg::ADDR_COUNT_HIGH;

    logic       clk;
    logic       rst_n;
    logic [7:0] addr;
    logic       wr_s;
    logic       rd_s;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] baddr;
    logic       bwr;
    logic       bdata;
    logic       hsel;
    logic       lsel;
    logic       cie;
    logic       rtc;
    logic       cmp;
    logic       irq;
    logic [7:0] v0;
    logic [7:0] v1;
    logic [7:0] v2;
    logic [7:0] v3;
    int         err_total = 0;
    int         checked = 0;
    int         cyc = 0;
    logic [7:0] ra[6] = '{CT, RL, RH, CL, CH, 8'hC9};
    // per external-select code: sys/12, rtc/8, reserved, comparator
    logic [7:0] lo_t[4] = '{8'h1A, 8'h02, 8'h00, 8'h10};
    logic [7:0] hi_t[4] = '{8'h1D, 8'h02, 8'h00, 8'h10};

    arc_timer dut (
        .core_clk               (clk),
        .reset_n                (rst_n),
        .sfr_addr               (addr),
        .sfr_wr                 (wr_s),
        .sfr_rd                 (rd_s),
        .sfr_wdata              (wdata),
        .sfr_rdata              (rdata),
        .bit_addr               (baddr),
        .bit_wr                 (bwr),
        .bit_wdata              (bdata),
        .high_half_clock_select (hsel),
        .low_half_clock_select  (lsel),
        .core_timer_irq_enable  (cie),
        .rtc_clk_in             (rtc),
        .cmp0_out               (cmp),
        .timer_irq              (irq)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // run is about two thousand cycles; this leaves ample slack
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] lo,
                       input logic [15:0] hi, input string s);
        logic ok;
        ok = (got >= lo) && (got <= hi);
        checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("BAD %0t %s got %h", $time, s, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        tick(1);
        wr_s  <= 1'b0;
        tick(1);
    endtask

    task automatic bw(input logic [7:0] a, input logic b);
        baddr <= a;
        bdata <= b;
        bwr   <= 1'b1;
        tick(1);
        bwr   <= 1'b0;
        tick(1);
    endtask

    // data is registered a cycle after the strobe and then holds
    task automatic rv(input logic [7:0] a, output logic [7:0] v);
        addr <= a;
        rd_s <= 1'b1;
        tick(1);
        rd_s <= 1'b0;
        tick(2);
        v = rdata;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] lo,
                      input logic [7:0] hi, input string s);
        logic [7:0] v;
        rv(a, v);
        chk({8'h00, v & m}, {8'h00, lo}, {8'h00, hi}, s);
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            rtc <= 1'b1;
            cmp <= 1'b1;
            tick(10);
            rtc <= 1'b0;
            cmp <= 1'b0;
            tick(10);
        end
    endtask

    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        wdata = 8'h00;
        baddr = 8'h00;
        bwr = 1'b0;
        bdata = 1'b0;
        hsel = 1'b0;
        lsel = 1'b0;
        cie = 1'b1;
        rtc = 1'b0;
        cmp = 1'b0;
        tick(5);
        rst_n <= 1'b1;
        tick(2);
        for (int i = 0; i < 6; i++) rc(ra[i], 8'hFF, 8'h00, 8'h00, "reset");
        wr(CL, 8'h5A);
        wr(CH, 8'hA5);
        rc(CL, 8'hFF, 8'h5A, 8'h5A, "low half");
        rc(CH, 8'hFF, 8'hA5, 8'hA5, "high half");
        wr(CT, 8'h2B);
        bw(CT + 8'h02, 1'b1);
        rc(CT, 8'hFF, 8'h2F, 8'h2F, "control bits");
        wr(CT, 8'h00);
        $display("test registers finished");
        lsel <= 1'b1;
        wr(CL, 8'hFE);
        wr(CH, 8'hFF);
        wr(RL, 8'h34);
        wr(RH, 8'h12);
        bw(CT + 8'h02, 1'b1);
        tick(4);
        bw(CT + 8'h02, 1'b0);
        rc(CH, 8'hFF, 8'h12, 8'h12, "16-bit reload high");
        rc(CL, 8'hFF, 8'h34, 8'h3F, "16-bit reload low");
        rc(CT, 8'h80, 8'h80, 8'h80, "high flag");
        chk({15'h0000, irq}, 16'h0001, 16'h0001, "irq full wrap");
        tick(30);
        rc(CT, 8'h80, 8'h80, 8'h80, "flag kept");
        wr(CT, 8'h00);
        tick(3);
        chk({15'h0000, irq}, 16'h0000, 16'h0000, "irq cleared");
        $display("test 16-bit finished");
        wr(CL, 8'hFE);
        wr(CH, 8'h00);
        wr(CT, 8'h24);
        tick(6);
        bw(CT + 8'h02, 1'b0);
        rc(CH, 8'hFF, 8'h01, 8'h01, "carry");
        rc(CT, 8'hC0, 8'h40, 8'h40, "low flag only");
        chk({15'h0000, irq}, 16'h0001, 16'h0001, "irq low wrap");
        wr(CT, 8'h00);
        $display("test low wrap finished");
        hsel <= 1'b1;
        wr(RL, 8'h40);
        wr(RH, 8'h80);
        wr(CL, 8'hFE);
        wr(CH, 8'hFE);
        wr(CT, 8'h08);
        tick(8);
        rc(CH, 8'hFF, 8'hFE, 8'hFE, "high held");
        rc(CL, 8'hF0, 8'h40, 8'h40, "low reload");
        rc(CT, 8'hC0, 8'h40, 8'h40, "split low flag");
        chk({15'h0000, irq}, 16'h0000, 16'h0000, "no irq low");
        bw(CT + 8'h02, 1'b1);
        tick(4);
        bw(CT + 8'h02, 1'b0);
        rc(CH, 8'hF0, 8'h80, 8'h80, "high reload");
        rc(CT, 8'h80, 8'h80, 8'h80, "split high flag");
        chk({15'h0000, irq}, 16'h0001, 16'h0001, "irq high");
        wr(CT, 8'h00);
        hsel <= 1'b0;
        lsel <= 1'b0;
        $display("test split finished");
        for (int c = 0; c < 4; c++) begin
            wr(CL, 8'h00);
            wr(CH, 8'h00);
            wr(CT, 8'h04 | 8'(c));
            pulse(16);
            tick(10);
            wr(CT, 8'h00);
            rc(CL, 8'hFF, lo_t[c], hi_t[c], "clock source");
        end
        $display("test sources finished");
        lsel <= 1'b1;
        wr(CL, 8'h00);
        wr(CH, 8'h00);
        wr(CT, 8'h17);
        pulse(1);
        rv(RL, v0);
        rv(RH, v1);
        pulse(1);
        rv(RL, v2);
        rv(RH, v3);
        chk({v3, v2} - {v1, v0}, 16'h001A, 16'h001A, "capture gap");
        rc(CT, 8'h80, 8'h80, 8'h80, "capture flag");
        chk({15'h0000, irq}, 16'h0001, 16'h0001, "capture irq");
        cie <= 1'b0;
        tick(3);
        chk({15'h0000, irq}, 16'h0000, 16'h0000, "irq masked");
        cie <= 1'b1;
        wr(CT, 8'h15);
        pulse(8);
        tick(10);
        rc(CT, 8'h80, 8'h80, 8'h80, "rtc capture");
        wr(CT, 8'h04);
        pulse(8);
        tick(10);
        rc(CT, 8'h80, 8'h00, 8'h00, "capture off");
        $display("test capture finished");
        wrap_up();
    end
endmodule
